// >>> pcr_pkg.sv
/*
 package for the process context register block: field positions,
 write mask bit positions, reset values and mode encodings.
 assumes nothing of its surroundings.
*/
package pcr_pkg;

    // ==========================================================
    // field positions
    localparam int SPACE_LSB     = 39;
    localparam int SPACE_MSB     = 46;
    localparam int TRQ_LSB       = 9;
    localparam int TRQ_MSB       = 12;
    localparam int TEN_LSB       = 5;
    localparam int TEN_MSB       = 8;
    localparam int FLOAT_BIT     = 2;
    localparam int COUNT_BIT     = 1;

    // ==========================================================
    // index decode and write mask positions
    localparam logic [1:0] SEL_CODE = 2'h1;
    localparam int SEL_LSB       = 6;
    localparam int SEL_MSB       = 7;
    localparam int WM_SPACE      = 0;
    localparam int WM_TEN        = 1;
    localparam int WM_TRQ        = 2;
    localparam int WM_COUNT      = 3;
    localparam int WM_FLOAT      = 4;

    // ==========================================================
    // reset values
    localparam logic [7:0] SPACE_RST = 8'h00;
    localparam logic [3:0] TRQ_RST   = 4'h0;
    localparam logic [3:0] TEN_RST   = 4'h0;
    localparam logic       FLOAT_RST = 1'b1;
    localparam logic       COUNT_RST = 1'b0;

    // ==========================================================
    // mode encodings: bit index inside request/enable fields is the mode value
    localparam logic [1:0] MODE_KERNEL = 2'h0;
    localparam logic [1:0] MODE_EXEC   = 2'h1;
    localparam logic [1:0] MODE_SUPER  = 2'h2;
    localparam logic [1:0] MODE_USER   = 2'h3;

endpackage

// >>> pcr_trap_gate.sv
/*
 one trap gate: combines request, enable, global trap enable and
 the current mode for a single processor mode.
 assumes the current mode comes from the processor status each cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module pcr_trap_gate
    import pcr_pkg::*;
#(
    parameter logic [1:0] GATE_MODE = 2'h0
) (
    input  wire logic       request,
    input  wire logic       enable,
    input  wire logic       trap_interrupt_enable,
    input  wire logic [1:0] current_mode,
    output logic            trap_out
);
    // ==========================================================
    // gating
    // mode values grow from kernel 0 to user 3
    assign trap_out = request && enable && trap_interrupt_enable
                      && (current_mode >= GATE_MODE);
endmodule
`default_nettype wire

// >>> pcr_top.sv
/*
 process context register: a 64-bit register written by masked
 move-to and read by move-from processor register instructions; drives
 per-mode trap requests, the float disabled fault and counter enables.
 assumes move instructions arrive as single-cycle strobes synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - four trap request bits, user 12, supervisor 11, executive 10, kernel 9
// - trap raised only if request, enable and global trap enable all set
// - trap raised only if current mode is at or above requested mode
// - four trap enable bits, user 8, supervisor 7, executive 6, kernel 5
// - float enable clear makes every float instruction fault instead
// - float enable is one after reset
// - per-process enable at bit 1 qualifies each counter's own enable
// - system-wide count enable is an alternative qualifier
// - index bits 7:6 equal 01 select; bits 4:0 mask fields written
// - mask: 0 space number, 1 trap enables, 2 requests, 3 count enable, 4 float
// - read returns all fields together in one 64-bit word
module pcr_top
    import pcr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        move_to_proc_reg,
    input  wire logic [7:0]  reg_index,
    input  wire logic [63:0] write_data,
    output logic             read_data_select,
    output logic [63:0]      read_data,
    input  wire logic        trap_interrupt_enable,
    input  wire logic [1:0]  processor_status_mode,
    output logic [3:0]       async_system_trap,
    input  wire logic        float_instr_valid,
    output logic             float_disabled_fault,
    input  wire logic        system_count_enable,
    input  wire logic        counter_zero_enable,
    input  wire logic        counter_one_enable,
    output logic             perf_counter_zero_run,
    output logic             perf_counter_one_run,
    output logic [7:0]       address_space_number
);

    // ==========================================================
    // reset release
    logic       rst_meta_n;
    logic       rst_sync_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // ==========================================================
    // register fields
    logic [3:0] trap_request_bits;
    logic [3:0] trap_enable_bits;
    logic       float_enable;
    logic       per_process_count_enable;
    logic       write_hit;

    assign write_hit = move_to_proc_reg
                       && (reg_index[SEL_MSB:SEL_LSB] == SEL_CODE);

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            address_space_number <= SPACE_RST;
        end else if (clk_en && write_hit && reg_index[WM_SPACE]) begin
            address_space_number <= write_data[SPACE_MSB:SPACE_LSB];
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            trap_enable_bits <= TEN_RST;
        end else if (clk_en && write_hit && reg_index[WM_TEN]) begin
            trap_enable_bits <= write_data[TEN_MSB:TEN_LSB];
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            trap_request_bits <= TRQ_RST;
        end else if (clk_en && write_hit && reg_index[WM_TRQ]) begin
            trap_request_bits <= write_data[TRQ_MSB:TRQ_LSB];
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            per_process_count_enable <= COUNT_RST;
        end else if (clk_en && write_hit && reg_index[WM_COUNT]) begin
            per_process_count_enable <= write_data[COUNT_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            float_enable <= FLOAT_RST;
        end else if (clk_en && write_hit && reg_index[WM_FLOAT]) begin
            float_enable <= write_data[FLOAT_BIT];
        end
    end

    // ==========================================================
    // read view
    // read is combinational on the held fields, so it always shows current state
    logic [63:0] next_read;

    always_comb begin
        next_read                  = 64'h0;
        next_read[SPACE_MSB:SPACE_LSB] = address_space_number;
        next_read[TRQ_MSB:TRQ_LSB]     = trap_request_bits;
        next_read[TEN_MSB:TEN_LSB]     = trap_enable_bits;
        next_read[FLOAT_BIT]           = float_enable;
        next_read[COUNT_BIT]           = per_process_count_enable;
    end

    assign read_data        = next_read;
    assign read_data_select = 1'b1;

    // ==========================================================
    // trap gating, one gate per mode
    pcr_trap_gate #(.GATE_MODE(MODE_KERNEL)) u_gate_kernel (
        .request               (trap_request_bits[0]),
        .enable                (trap_enable_bits[0]),
        .trap_interrupt_enable (trap_interrupt_enable),
        .current_mode          (processor_status_mode),
        .trap_out              (async_system_trap[0])
    );
    pcr_trap_gate #(.GATE_MODE(MODE_EXEC)) u_gate_exec (
        .request               (trap_request_bits[1]),
        .enable                (trap_enable_bits[1]),
        .trap_interrupt_enable (trap_interrupt_enable),
        .current_mode          (processor_status_mode),
        .trap_out              (async_system_trap[1])
    );
    pcr_trap_gate #(.GATE_MODE(MODE_SUPER)) u_gate_super (
        .request               (trap_request_bits[2]),
        .enable                (trap_enable_bits[2]),
        .trap_interrupt_enable (trap_interrupt_enable),
        .current_mode          (processor_status_mode),
        .trap_out              (async_system_trap[2])
    );
    pcr_trap_gate #(.GATE_MODE(MODE_USER)) u_gate_user (
        .request               (trap_request_bits[3]),
        .enable                (trap_enable_bits[3]),
        .trap_interrupt_enable (trap_interrupt_enable),
        .current_mode          (processor_status_mode),
        .trap_out              (async_system_trap[3])
    );

    // ==========================================================
    // float fault and counter enables
    assign float_disabled_fault = float_instr_valid && !float_enable;

    logic count_qualify;
    assign count_qualify = per_process_count_enable
                           || system_count_enable;
    assign perf_counter_zero_run = counter_zero_enable && count_qualify;
    assign perf_counter_one_run  = counter_one_enable && count_qualify;

endmodule
`default_nettype wire

// >>> pcr_monitor.sv
/*
 checker for the process context register top ports.
 assumes a bind onto pcr_top and a single clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module pcr_monitor
    import pcr_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        clk_en,
    input wire logic        move_to_proc_reg,
    input wire logic [7:0]  reg_index,
    input wire logic [63:0] write_data,
    input wire logic [63:0] read_data,
    input wire logic        trap_interrupt_enable,
    input wire logic [1:0]  processor_status_mode,
    input wire logic [3:0]  async_system_trap,
    input wire logic        float_instr_valid,
    input wire logic        float_disabled_fault,
    input wire logic        system_count_enable,
    input wire logic        counter_zero_enable,
    input wire logic        counter_one_enable,
    input wire logic        perf_counter_zero_run,
    input wire logic        perf_counter_one_run,
    input wire logic [7:0]  address_space_number
);
    // ==========================================================
    // helpers
    logic       wr;
    logic [3:0] trap_exp;
    assign wr = clk_en && move_to_proc_reg && reg_index[7:6] == 2'h1;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            trap_exp[i] = read_data[9+i] & read_data[5+i] & trap_interrupt_enable
                          & (processor_status_mode >= 2'(i));
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    trap_gate_a: assert property (async_system_trap == trap_exp)
        else $error("trap output differs from gate");
    fault_gate_a: assert property (
        float_disabled_fault == (float_instr_valid & !read_data[2]))
        else $error("float fault wrong");
    run_zero_a: assert property (
        perf_counter_zero_run == (counter_zero_enable & (read_data[1] | system_count_enable)))
        else $error("counter zero run wrong");
    run_one_a: assert property (
        perf_counter_one_run == (counter_one_enable & (read_data[1] | system_count_enable)))
        else $error("counter one run wrong");
    reserved_zero_a: assert property (
        read_data[63:47] == 17'h0 && read_data[38:13] == 26'h0 && read_data[4:3] == 2'h0
        && !read_data[0])
        else $error("reserved bits set");
    float_load_a: assert property (wr && reg_index[4]
        |=> read_data[2] == $past(write_data[2]))
        else $error("float enable not loaded");
    space_load_a: assert property (wr && reg_index[0]
        |=> address_space_number == $past(write_data[46:39]))
        else $error("address space number not loaded");
    request_keep_a: assert property (wr && !reg_index[2] |=> $stable(read_data[12:9]))
        else $error("unmasked requests changed");
    idle_hold_a: assert property (!wr |=> $stable(read_data))
        else $error("register changed without write");
endmodule
`default_nettype wire

// >>> testbench.sv
/*
 self-checking testbench for pcr_top.
 assumes pcr_pkg and pcr_monitor are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pcr_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, move_to_proc_reg = 1'b0;
    logic [7:0] reg_index = 8'h00, address_space_number;
    logic [63:0] write_data = 64'h0, read_data;
    logic trap_interrupt_enable = 1'b0, float_instr_valid = 1'b0, float_disabled_fault;
    logic [1:0] processor_status_mode = 2'h0;
    logic [3:0] async_system_trap;
    logic system_count_enable = 1'b0, counter_zero_enable = 1'b0, counter_one_enable = 1'b0;
    logic perf_counter_zero_run, perf_counter_one_run, read_data_select;
    int miscompares = 0;
    int checks = 0;
    always #5 clk = ~clk;
    pcr_top i_dut (
        .clk                   (clk),
        .rst_n                 (rst_n),
        .clk_en                (clk_en),
        .move_to_proc_reg      (move_to_proc_reg),
        .reg_index             (reg_index),
        .write_data            (write_data),
        .read_data_select      (read_data_select),
        .read_data             (read_data),
        .trap_interrupt_enable (trap_interrupt_enable),
        .processor_status_mode (processor_status_mode),
        .async_system_trap     (async_system_trap),
        .float_instr_valid     (float_instr_valid),
        .float_disabled_fault  (float_disabled_fault),
        .system_count_enable   (system_count_enable),
        .counter_zero_enable   (counter_zero_enable),
        .counter_one_enable    (counter_one_enable),
        .perf_counter_zero_run (perf_counter_zero_run),
        .perf_counter_one_run  (perf_counter_one_run),
        .address_space_number  (address_space_number)
    );
    // ==========================================================
    // shared tasks
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [63:0] d);
        @(negedge clk);
        move_to_proc_reg = 1'b1;
        reg_index = idx;
        write_data = d;
        @(negedge clk);
        move_to_proc_reg = 1'b0;
    endtask
    task automatic print_verdict;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_float;
        float_instr_valid = 1'b1;
        #1 chk(read_data, 64'h4);
        chk(float_disabled_fault, 0);
        wr(8'h50, 64'h0);
        chk(read_data, 64'h0);
        chk(float_disabled_fault, 1);
        float_instr_valid = 1'b0;
        #1 chk(float_disabled_fault, 0);
        $display("test float done");
    endtask
    task automatic t_mask;
        wr(8'h5F, '1);
        chk(read_data, 64'h0000_7F80_0000_1FE6);
        chk(address_space_number, 8'hFF);
        chk(read_data_select, 1'b1);
        wr(8'h9F, 64'h0); // wrong select code must be ignored
        clk_en = 1'b0;
        wr(8'h5F, 64'h0);
        clk_en = 1'b1;
        chk(read_data, 64'h0000_7F80_0000_1FE6);
        wr(8'h41, 64'h0);
        chk(read_data, 64'h1FE6);
        chk(address_space_number, 8'h00);
        $display("test mask done");
    endtask
    task automatic t_traps;
        logic [3:0] exp_trap;
        for (int t = 0; t < 2; t++) begin
            for (int m = 0; m < 4; m++) begin
                trap_interrupt_enable = t[0];
                processor_status_mode = 2'(m);
                exp_trap = t ? 4'((5'h1 << (m + 1)) - 1) : 4'h0;
                #1 chk(async_system_trap, exp_trap);
                @(negedge clk);
            end
        end
        wr(8'h46, 64'h1E20);
        chk(async_system_trap, 4'h1);
        $display("test traps done");
    endtask
    task automatic t_count;
        for (int k = 0; k < 16; k++) begin
            wr(8'h48, {62'h0, k[0], 1'b0});
            system_count_enable = k[1];
            counter_zero_enable = k[2];
            counter_one_enable = k[3];
            #1 chk(perf_counter_zero_run, k[2] & (k[0] | k[1]));
            chk(perf_counter_one_run, k[3] & (k[0] | k[1]));
        end
        $display("test count done");
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        t_float();
        t_mask();
        t_traps();
        t_count();
        print_verdict();
    end
    initial begin
        #20000;
        miscompares++;
        print_verdict();
    end
endmodule
bind pcr_top pcr_monitor i_mon (
    .clk                   (clk),
    .rst_n                 (rst_n),
    .clk_en                (clk_en),
    .move_to_proc_reg      (move_to_proc_reg),
    .reg_index             (reg_index),
    .write_data            (write_data),
    .read_data             (read_data),
    .trap_interrupt_enable (trap_interrupt_enable),
    .processor_status_mode (processor_status_mode),
    .async_system_trap     (async_system_trap),
    .float_instr_valid     (float_instr_valid),
    .float_disabled_fault  (float_disabled_fault),
    .system_count_enable   (system_count_enable),
    .counter_zero_enable   (counter_zero_enable),
    .counter_one_enable    (counter_one_enable),
    .perf_counter_zero_run (perf_counter_zero_run),
    .perf_counter_one_run  (perf_counter_one_run),
    .address_space_number  (address_space_number)
);
`default_nettype wire
